// [design/scs_pkg.sv]
// package for the system clock switch and fail-safe monitor
// assumes a single 250 MHz core clock; oscillator pins are sampled in that domain
package scs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on AHB-Lite, one word per register)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_OSC_CONTROL = 8'h00;
  localparam logic [7:0] OFF_PERIPH_FLAGS2 = 8'h04;
  localparam logic [7:0] OFF_PERIPH_ENABLES2 = 8'h08;
  localparam int ADDR_W = 8;

  // oscillator_control fields
  localparam int IFS_MSB = 6;
  localparam int IFS_LSB = 4;
  localparam int STARTUP_STATUS_BIT = 3;
  localparam int HF_STABLE_BIT = 2;
  localparam int LF_STABLE_BIT = 1;
  localparam int CLOCK_SELECT_BIT = 0;
  localparam logic [2:0] IFS_RESET = 3'h6;
  localparam logic [2:0] IFS_LF_OSC = 3'h0;
  localparam logic CLOCK_SELECT_RESET = 1'b0;
  localparam logic STARTUP_STATUS_RESET = 1'b0;

  // peripheral_flags_2 / peripheral_enables_2 field
  localparam int OSC_FAIL_BIT = 7;

  // configured oscillator modes
  localparam logic [2:0] MODE_LP = 3'h0;
  localparam logic [2:0] MODE_XT = 3'h1;
  localparam logic [2:0] MODE_HS = 3'h2;
  localparam logic [2:0] MODE_EC = 3'h3;
  localparam logic [2:0] MODE_INT_IO = 3'h4;
  localparam logic [2:0] MODE_INT = 3'h5;
  localparam logic [2:0] MODE_RC_IO = 3'h6;
  localparam logic [2:0] MODE_RC = 3'h7;

  // timing counts
  localparam int OST_COUNT = 1024;
  localparam int SAMPLE_DIV = 64;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] osc_mode;
    logic switchover_enable;
    logic failsafe_enable;
  } scs_cfg_s;

  typedef struct packed {
    logic src_ext;
    logic clk_hold;
    logic cpu_run;
    logic lf_sel;
    logic [2:0] int_freq_select;
  } scs_ctl_s;

  typedef enum logic [1:0] {
    HT_IDLE = 2'h0,
    HT_BUSY = 2'h1,
    HT_NONSEQ = 2'h2,
    HT_SEQ = 2'h3
  } scs_htrans_e;

endpackage

// [design/scs_clock_switch.sv]
// system clock switch with two-speed start-up and fail-safe clock monitor
// assumes: config straps stable after reset, oscillator pins asynchronous to core_clk_i,
// sleep_i and powerup_timer_done_i driven by logic on core_clk_i
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - freq select 111..001 halves, 000 low osc
// - freq select resets to 110, 4 MHz
// - startup status set while running external
// - startup status resets to zero
// - bits 2 and 1 report oscillator stability
// - clock select 1 internal, 0 configured source
// - reset clears clock select
// - automatic switches never change clock select
// - sleep aborts start-up, status stays clear
// - crystal modes count 1024 external cycles
// - two-speed needs switchover, select 0, crystal
// - sequence starts after reset/powerup timer, wake
// - non-crystal modes skip two-speed start-up
// - timeout, internal fall, status, hold, switch
// - monitor enabled by config, after timer only
// - sample clock is low osc divided 64
// - latch set ext fall, cleared sample rise
// - fail if half sample cycle without fall
// - fail: go internal, set flag, interrupt
// - reset, sleep or select toggle clears fail
// - flag uncleared while fail condition persists
// - ext/RC: monitor immediate; monitor enables two-speed
// - fail flag is bit 7, software clears
module scs_clock_switch #(
  parameter int OST_CYCLES = scs_pkg::OST_COUNT,
  parameter int SAMPLE_DIVIDE = scs_pkg::SAMPLE_DIV
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire scs_pkg::scs_cfg_s cfg_i,
  input wire logic powerup_timer_done_i,
  input wire logic sleep_i,
  input wire logic ext_clk_i,
  input wire logic int_osc_i,
  input wire logic lf_osc_i,
  input wire logic hf_stable_i,
  input wire logic lf_stable_i,
  output scs_pkg::scs_ctl_s ctl_o,
  output logic osc_fail_irq_o
);

  typedef enum logic [2:0] {
    ST_SLEEP, ST_START, ST_OST, ST_INT_EDGE, ST_HOLD, ST_EXT, ST_FAIL, ST_INT
  } scs_state_e;

  localparam int OST_W = $clog2(OST_CYCLES + 1);
  localparam int DIV_W = $clog2(SAMPLE_DIVIDE);
  localparam logic [OST_W-1:0] OST_LAST = OST_W'(OST_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_HALF_LAST = DIV_W'(SAMPLE_DIVIDE / 2 - 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [2:0] prev_r;
  logic ext_fall;
  logic int_fall;
  logic lf_rise;

  always_ff @(posedge core_clk_i)
  begin
    sync1_r <= {lf_stable_i, hf_stable_i, lf_osc_i, int_osc_i, ext_clk_i};
    sync2_r <= sync1_r;
    prev_r <= sync2_r[2:0];
  end

  assign ext_fall = prev_r[0] & ~sync2_r[0];
  assign int_fall = prev_r[1] & ~sync2_r[1];
  assign lf_rise = ~prev_r[2] & sync2_r[2];

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic crystal_mode;
  logic external_mode;
  logic two_speed;
  logic scs_r;
  logic [2:0] ifs_r;

  assign crystal_mode = (cfg_i.osc_mode == scs_pkg::MODE_LP) || (cfg_i.osc_mode == scs_pkg::MODE_XT) ||
    (cfg_i.osc_mode == scs_pkg::MODE_HS);
  assign external_mode = (cfg_i.osc_mode != scs_pkg::MODE_INT_IO) && (cfg_i.osc_mode != scs_pkg::MODE_INT);
  // the monitor drags two-speed in with it so code runs during the count
  assign two_speed = crystal_mode & ((cfg_i.switchover_enable & ~scs_r) | cfg_i.failsafe_enable);

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  logic dp_wr_r;
  logic [scs_pkg::ADDR_W-1:0] dp_addr_r;
  logic addr_phase;
  logic wr_ctl;
  logic wr_flags;
  logic wr_enables;
  logic [7:0] rd_val;
  logic startup_status_r;
  logic fail_flag_r;
  logic fail_en_r;

  assign addr_phase = hsel_i & hready_i & htrans_i[1];
  assign wr_ctl = dp_wr_r & (dp_addr_r == scs_pkg::OFF_OSC_CONTROL);
  assign wr_flags = dp_wr_r & (dp_addr_r == scs_pkg::OFF_PERIPH_FLAGS2);
  assign wr_enables = dp_wr_r & (dp_addr_r == scs_pkg::OFF_PERIPH_ENABLES2);

  always_comb
  begin
    rd_val = 8'h00;
    case (haddr_i[scs_pkg::ADDR_W-1:0])
      scs_pkg::OFF_OSC_CONTROL: rd_val = {1'b0, ifs_r, startup_status_r, sync2_r[3], sync2_r[4], scs_r};
      scs_pkg::OFF_PERIPH_FLAGS2: rd_val = {fail_flag_r, 7'h00};
      scs_pkg::OFF_PERIPH_ENABLES2: rd_val = {fail_en_r, 7'h00};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= '0;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      dp_wr_r <= addr_phase & hwrite_i;
      dp_addr_r <= haddr_i[scs_pkg::ADDR_W-1:0];
      if (addr_phase && !hwrite_i)
        hrdata_o <= {24'h00_0000, rd_val};
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software fields
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      ifs_r <= scs_pkg::IFS_RESET;
      scs_r <= scs_pkg::CLOCK_SELECT_RESET;
      fail_en_r <= 1'b0;
    end
    else
    begin
      // only a bus write moves the select; automatic switches leave it alone
      if (wr_ctl)
      begin
        ifs_r <= hwdata_i[scs_pkg::IFS_MSB:scs_pkg::IFS_LSB];
        scs_r <= hwdata_i[scs_pkg::CLOCK_SELECT_BIT];
      end
      if (wr_enables)
        fail_en_r <= hwdata_i[scs_pkg::OSC_FAIL_BIT];
    end
  end

  logic scs_toggle;
  assign scs_toggle = wr_ctl & (hwdata_i[scs_pkg::CLOCK_SELECT_BIT] != scs_r);

  // ----------------------------------------------------------------
  // fail detector and sample clock
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt_r;
  logic sample_r;
  logic sample_rise;
  logic sample_fall;
  logic latch_r;
  logic monitor_on;
  logic fail_det;
  scs_state_e state_r;
  scs_state_e state_nxt;

  assign sample_rise = lf_rise & (div_cnt_r == DIV_HALF_LAST) & ~sample_r;
  assign sample_fall = lf_rise & (div_cnt_r == DIV_HALF_LAST) & sample_r;

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      div_cnt_r <= '0;
      sample_r <= 1'b0;
    end
    else if (lf_rise)
    begin
      div_cnt_r <= (div_cnt_r == DIV_HALF_LAST) ? '0 : div_cnt_r + 1'b1;
      if (div_cnt_r == DIV_HALF_LAST)
        sample_r <= ~sample_r;
    end
  end

  // only watches in the external-running state (after the start-up count in crystal modes), in an external mode
  assign monitor_on = cfg_i.failsafe_enable & external_mode & (state_r == ST_EXT);
  // latch checked half a sample period after it was cleared
  assign fail_det = monitor_on & sample_fall & ~latch_r;

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      latch_r <= 1'b1;
    else if (!monitor_on || ext_fall)
      latch_r <= 1'b1;
    else if (sample_rise)
      latch_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  logic [OST_W-1:0] ost_cnt_r;
  logic ost_done;
  logic por_wait_r;
  logic fail_cond_r;

  assign ost_done = ext_fall & (ost_cnt_r == OST_LAST);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_SLEEP: if (!sleep_i) state_nxt = ST_START;
      ST_START:
      begin
        if (por_wait_r && !powerup_timer_done_i)
          state_nxt = ST_START;
        else if (scs_r && !fail_cond_r)
          state_nxt = ST_INT;
        else if (crystal_mode)
          state_nxt = ST_OST;
        else
          state_nxt = ST_EXT;
      end
      ST_OST:
      begin
        if (scs_r && !fail_cond_r)
          state_nxt = ST_INT;
        else if (ost_done)
          state_nxt = ST_INT_EDGE;
      end
      ST_INT_EDGE: if (int_fall) state_nxt = ST_HOLD;
      ST_HOLD: if (ext_fall) state_nxt = ST_EXT;
      ST_EXT:
      begin
        if (fail_det)
          state_nxt = ST_FAIL;
        else if (scs_r)
          state_nxt = ST_INT;
      end
      ST_FAIL: if (scs_toggle) state_nxt = ST_START;
      ST_INT: if (!scs_r) state_nxt = ST_START;
      default: state_nxt = ST_START;
    endcase
    if (sleep_i)
      state_nxt = ST_SLEEP;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      state_r <= ST_START;
      por_wait_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_START && powerup_timer_done_i)
        por_wait_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i || state_r != ST_OST)
      ost_cnt_r <= '0;
    else if (ext_fall && ost_cnt_r != OST_LAST)
      ost_cnt_r <= ost_cnt_r + 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      fail_cond_r <= 1'b0;
    else if (state_nxt == ST_SLEEP)
      fail_cond_r <= 1'b0;
    else if (fail_det)
      fail_cond_r <= 1'b1;
    else if ((state_r != ST_EXT && state_nxt == ST_EXT) || state_nxt == ST_INT_EDGE)
      fail_cond_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      startup_status_r <= scs_pkg::STARTUP_STATUS_RESET;
    else
      startup_status_r <= (state_nxt == ST_HOLD) || (state_nxt == ST_EXT);
  end

  // ----------------------------------------------------------------
  // fail flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      fail_flag_r <= 1'b0;
    else if (fail_det)
      fail_flag_r <= 1'b1;
    else if (wr_flags && !hwdata_i[scs_pkg::OSC_FAIL_BIT] && !fail_cond_r)
      fail_flag_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      osc_fail_irq_o <= 1'b0;
    else
      osc_fail_irq_o <= fail_flag_r & fail_en_r;
  end

  // ----------------------------------------------------------------
  // clock mux controls
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      ctl_o <= '{src_ext: 1'b0, clk_hold: 1'b0, cpu_run: 1'b0, lf_sel: 1'b0, int_freq_select: scs_pkg::IFS_RESET};
    else
    begin
      ctl_o.src_ext <= (state_r == ST_EXT);
      ctl_o.clk_hold <= (state_r == ST_HOLD);
      ctl_o.cpu_run <= (state_r == ST_EXT) || (state_r == ST_INT) || (state_r == ST_FAIL) ||
        (state_r == ST_INT_EDGE) || ((state_r == ST_OST) && two_speed);
      ctl_o.lf_sel <= (ifs_r == scs_pkg::IFS_LF_OSC);
      ctl_o.int_freq_select <= ifs_r;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_ifs_reset: assert property ($rose(resetn_i) |-> ifs_r == 3'h6)
    else $error("freq select not 110 after reset");
  // status follows the state one cycle ahead of the mux control
  a_status_ext: assert property (ctl_o.src_ext |-> $past(startup_status_r))
    else $error("running external with status clear");
  a_sleep_abort: assert property (sleep_i |=> !startup_status_r && !fail_cond_r)
    else $error("sleep left status or fail set");
  a_ost_halt: assert property (state_r == ST_OST && !two_speed |=> !ctl_o.cpu_run)
    else $error("execution during start-up count");
  a_scs_auto: assert property (!wr_ctl |=> $stable(scs_r))
    else $error("clock select moved without write");
  a_fail_switch: assert property (fail_det && !sleep_i
    |=> state_r == ST_FAIL && fail_flag_r ##1 !ctl_o.src_ext)
    else $error("failure did not switch to internal");
  a_flag_hold: assert property (fail_cond_r && fail_flag_r |=> fail_flag_r)
    else $error("fail flag cleared during fail condition");
  a_nocrystal_skip: assert property (state_r == ST_START && !crystal_mode && !scs_r && (!por_wait_r || powerup_timer_done_i)
    && !sleep_i |=> state_r == ST_EXT)
    else $error("non-crystal mode ran the start-up count");
  a_hold_order: assert property (state_r == ST_HOLD && !sleep_i |-> startup_status_r ##1 ctl_o.clk_hold)
    else $error("hold low before status set");
  a_monitor_gate: assert property (state_r != ST_EXT || !cfg_i.failsafe_enable |=> !$rose(fail_flag_r))
    else $error("fail flag raised while monitor was off");

  c_fail: cover property (fail_det);
  c_ext_entry: cover property (state_r == ST_HOLD ##1 state_r == ST_EXT);
  c_wake: cover property (state_r == ST_SLEEP ##1 state_r == ST_START);
  c_fail_recover: cover property (state_r == ST_FAIL ##1 state_r == ST_START);

endmodule

`default_nettype wire

// [verif/scs_xtal_model.sv]
// external crystal model driving the clock switch oscillator pin
// assumes the bench owns run_i; clears it to make the crystal fail
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// crystal model
// ----------------------------------------------------------------
module scs_xtal_model #(
  parameter int HALF_NS = 20
) (
  input wire logic run_i,
  output logic ext_clk_o
);
  initial ext_clk_o = 1'b0;

  // a dead crystal parks high, so no falling edge ever reaches the detector
  always
  begin
    #HALF_NS;
    ext_clk_o = run_i ? ~ext_clk_o : 1'b1;
  end
endmodule
`default_nettype wire

// [verif/test_system_clock_switch_failsafe.sv]
// self-checking bench for the system clock switch and fail-safe monitor
// assumes scs_xtal_model as the crystal; start-up and sample counts are shortened
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module test_system_clock_switch_failsafe;
  localparam int STARTUP_TIMER = 16;
  logic clk, rstn, hsel, hwrite, powerup_timer, slp, run, iosc, losc, hfs, lfs, hrdy, irq, ext, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  scs_pkg::scs_cfg_s cfg;
  scs_pkg::scs_ctl_s ctl;
  int num_errors;
  int checks;
  int cyc = 0;

  scs_clock_switch #(.OST_CYCLES(STARTUP_TIMER), .SAMPLE_DIVIDE(8)) u_scs_clock_switch (
    .core_clk_i(clk), .resetn_i(rstn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .cfg_i(cfg), .powerup_timer_done_i(powerup_timer),
    .sleep_i(slp), .ext_clk_i(ext), .int_osc_i(iosc), .lf_osc_i(losc),
    .hf_stable_i(hfs), .lf_stable_i(lfs), .ctl_o(ctl), .osc_fail_irq_o(irq)
  );
  scs_xtal_model u_scs_xtal_model (.run_i(run), .ext_clk_o(ext));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always #12 iosc = ~iosc;
  always #20 losc = ~losc;

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cchk(input logic [6:0] e);
    chk({25'h0, ctl}, {25'h0, e});
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_src(input logic v);
    int n;
    n = 0;
    while (ctl.src_ext !== v && n < 800)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, ctl.src_ext}, {31'h0, v});
  endtask

  // the clock is held low, neither source driving, before the switch
  task automatic wait_hold();
    int n;
    n = 0;
    while (ctl.clk_hold !== 1'b1 && n < 800)
    begin
      @(posedge clk);
      n++;
    end
    cchk(7'h26);
  endtask

  task automatic t_reset();
    cchk(7'h06);
    rdchk(8'h00, 32'h64);
    hfs <= 1'b0;
    lfs <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(8'h00, 32'h62);
    hfs <= 1'b1;
    bus(1'b1, 8'h0c, 32'hff);
    rdchk(8'h0c, 32'h0);
    rdchk(8'h04, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_freq();
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 8'h00, 32'(i << 4));
      repeat (2) @(posedge clk);
      cchk({3'b000, i == 0, 3'(i)});
      rdchk(8'h00, 32'(i << 4) | 32'h6);
    end
    bus(1'b1, 8'h00, 32'h60);
    $display("frequency test done");
  endtask

  task automatic t_twospeed();
    int t0;
    powerup_timer <= 1'b1;
    t0 = cyc;
    repeat (20) @(posedge clk);
    cchk(7'h16);
    rdchk(8'h00, 32'h66);
    wait_hold();
    wait_src(1'b1);
    chk(32'(cyc - t0 >= (STARTUP_TIMER - 1) * 10), 32'h1);
    cchk(7'h56);
    rdchk(8'h00, 32'h6e);
    $display("two-speed test done");
  endtask

  task automatic t_sleep();
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    cchk(7'h06);
    rdchk(8'h00, 32'h66);
    slp <= 1'b0;
    repeat (20) @(posedge clk);
    cchk(7'h16);
    wait_src(1'b1);
    $display("sleep test done");
  endtask

  task automatic t_fail();
    bus(1'b1, 8'h08, 32'h80);
    rdchk(8'h08, 32'h80);
    run <= 1'b0;
    wait_src(1'b0);
    repeat (2) @(posedge clk);
    cchk(7'h16);
    chk({31'h0, irq}, 32'h1);
    rdchk(8'h00, 32'h66);
    rdchk(8'h04, 32'h80);
    bus(1'b1, 8'h04, 32'h0);
    rdchk(8'h04, 32'h80);
    run <= 1'b1;
    bus(1'b1, 8'h00, 32'h61);
    repeat (300) @(posedge clk);
    cchk(7'h16);
    bus(1'b1, 8'h00, 32'h60);
    wait_src(1'b1);
    bus(1'b1, 8'h04, 32'h0);
    rdchk(8'h04, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("fail-safe test done");
  endtask

  task automatic t_extmode();
    bus(1'b1, 8'h00, 32'h61);
    rstn <= 1'b0;
    cfg <= {scs_pkg::MODE_EC, 1'b0, 1'b1};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    cchk(7'h56);
    rdchk(8'h00, 32'h6e);
    run <= 1'b0;
    wait_src(1'b0);
    rdchk(8'h04, 32'h80);
    run <= 1'b1;
    $display("external mode test done");
  endtask

  // crystal with neither switchover nor monitor: no execution during the count
  task automatic t_halt();
    rstn <= 1'b0;
    cfg <= {scs_pkg::MODE_XT, 1'b0, 1'b0};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    cchk(7'h06);
    wait_src(1'b1);
    bus(1'b1, 8'h00, 32'h61);
    repeat (4) @(posedge clk);
    cchk(7'h16);
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    slp <= 1'b0;
    repeat (20) @(posedge clk);
    cchk(7'h16);
    rdchk(8'h00, 32'h67);
    $display("halt test done");
  endtask

  initial
  begin
    rstn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    powerup_timer = 1'b0;
    slp = 1'b0;
    run = 1'b1;
    hfs = 1'b1;
    lfs = 1'b0;
    iosc = 1'b0;
    losc = 1'b0;
    cfg = {scs_pkg::MODE_XT, 1'b1, 1'b1};
    num_errors = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_freq();
    t_twospeed();
    t_sleep();
    t_fail();
    t_extmode();
    t_halt();
    close_out();
  end
endmodule
`default_nettype wire
